// [dst_defs.vh]
// Register map, field positions, reset values and divider constants
`ifndef DST_DEFS_VH
`define DST_DEFS_VH

// Register byte addresses
`define DST_ADDR_TX_LOW 8'h18
`define DST_ADDR_TX_HIGH 8'h19
`define DST_ADDR_TY_LOW 8'h1A
`define DST_ADDR_TY_HIGH 8'h1B
`define DST_ADDR_TXM 8'h1C
`define DST_ADDR_IRQ 8'h1D
`define DST_ADDR_TYM 8'h1F

// First timer mode register fields
`define DST_TXM_WRCTL 0
`define DST_TXM_MODE_LO 1
`define DST_TXM_MODE_HI 2
`define DST_TXM_POL 3
`define DST_TXM_STOP 7
`define DST_TXM_USED 8'h8F

// First timer modes
`define DST_TX_TIMER 2'h0
`define DST_TX_BIPHASE 2'h1
`define DST_TX_EVENT 2'h2
`define DST_TX_PWIDTH 2'h3

// Second timer mode register fields
`define DST_TYM_XDIV_LO 0
`define DST_TYM_XDIV_HI 1
`define DST_TYM_YDIV_LO 2
`define DST_TYM_YDIV_HI 3
`define DST_TYM_MODE_LO 4
`define DST_TYM_MODE_HI 5
`define DST_TYM_POL 6
`define DST_TYM_STOP 7

// Second timer modes
`define DST_TY_TIMER 2'h0
`define DST_TY_PERIOD 2'h1
`define DST_TY_EVENT 2'h2
`define DST_TY_HLWIDTH 2'h3

// Request register bit positions
`define DST_IRQ_TX 0
`define DST_IRQ_TY 1
`define DST_IRQ_FIRST_TIMER_INPUT_PIN 2
`define DST_IRQ_SECOND_TIMER_INPUT_PIN 3

// Reset values
`define DST_TXM_RESET 8'h00
`define DST_TYM_RESET 8'h00
`define DST_TIMER_RESET 16'hFFFF

// Prescaler width: longest ratio is 128
`define DST_PRESCALE_W 7

`endif

// [dst_timers.v]
// Dual 16-bit timers, down-counting except the first timer's up/down biphase mode, with byte-ordered CPU access
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "dst_defs.vh"

module dst_timers (
    input wire sys_clk,
    input wire rstn,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    input wire first_timer_input_pin,
    input wire second_timer_input_pin,
    input wire phase_a_input_pin,
    output reg first_timer_irq,
    output reg second_timer_irq,
    output reg first_input_irq,
    output reg second_input_irq
);

////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta;
reg rst_n;

always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

////////////////////////////////////////////////////////////////////////////
// Registers and state

reg [7:0] first_timer_mode_reg;
reg [7:0] second_timer_mode_reg;
reg [15:0] tx_latch;
reg [15:0] tx_count;
reg [15:0] ty_latch;
reg [15:0] ty_count;
reg [15:0] ty_capture;
reg [7:0] tx_wr_low;
reg [7:0] ty_wr_low;
reg [7:0] tx_rd_low;
reg [7:0] ty_rd_low;
reg [`DST_PRESCALE_W-1:0] prescale;
reg first_timer_input_pin_prev;
reg second_timer_input_pin_prev;
reg phase_a_prev;

////////////////////////////////////////////////////////////////////////////
// Decode and field extraction

wire wr_tx_low = bus_wr && (bus_addr == `DST_ADDR_TX_LOW);
wire wr_tx_high = bus_wr && (bus_addr == `DST_ADDR_TX_HIGH);
wire wr_ty_low = bus_wr && (bus_addr == `DST_ADDR_TY_LOW);
wire wr_ty_high = bus_wr && (bus_addr == `DST_ADDR_TY_HIGH);
wire wr_txm = bus_wr && (bus_addr == `DST_ADDR_TXM);
wire wr_tym = bus_wr && (bus_addr == `DST_ADDR_TYM);
wire wr_irq = bus_wr && (bus_addr == `DST_ADDR_IRQ);
wire rd_tx_high = bus_rd && (bus_addr == `DST_ADDR_TX_HIGH);
wire rd_ty_high = bus_rd && (bus_addr == `DST_ADDR_TY_HIGH);

wire [1:0] tx_mode =
    first_timer_mode_reg[`DST_TXM_MODE_HI:`DST_TXM_MODE_LO];
wire tx_wrctl = first_timer_mode_reg[`DST_TXM_WRCTL];
wire tx_pol = first_timer_mode_reg[`DST_TXM_POL];
wire tx_stop = first_timer_mode_reg[`DST_TXM_STOP];
wire [1:0] tx_div_sel =
    second_timer_mode_reg[`DST_TYM_XDIV_HI:`DST_TYM_XDIV_LO];
wire [1:0] ty_div_sel =
    second_timer_mode_reg[`DST_TYM_YDIV_HI:`DST_TYM_YDIV_LO];
wire [1:0] ty_mode =
    second_timer_mode_reg[`DST_TYM_MODE_HI:`DST_TYM_MODE_LO];
wire ty_pol = second_timer_mode_reg[`DST_TYM_POL];
wire ty_stop = second_timer_mode_reg[`DST_TYM_STOP];

////////////////////////////////////////////////////////////////////////////
// Prescaler: one free counter, each ratio is a one-cycle tick

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        prescale <= {`DST_PRESCALE_W{1'b0}};
    end else begin
        prescale <= prescale + 1'b1;
    end
end

wire tick_4 = &prescale[1:0];
wire tick_8 = &prescale[2:0];
wire tick_16 = &prescale[3:0];
wire tick_32 = &prescale[4:0];
wire tick_128 = &prescale[6:0];

reg tx_tick;
reg ty_tick;

always @* begin
    case (tx_div_sel)
        2'h0: tx_tick = tick_4;
        2'h1: tx_tick = tick_8;
        2'h2: tx_tick = tick_16;
        2'h3: tx_tick = tick_128;
        default: tx_tick = 1'b0;
    endcase
    case (ty_div_sel)
        2'h0: ty_tick = tick_8;
        2'h1: ty_tick = tick_16;
        2'h2: ty_tick = tick_32;
        2'h3: ty_tick = tick_4;
        default: ty_tick = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// Input edges (pins are taken as synchronous)

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        first_timer_input_pin_prev <= 1'b0;
        second_timer_input_pin_prev <= 1'b0;
        phase_a_prev <= 1'b0;
    end else begin
        first_timer_input_pin_prev <= first_timer_input_pin;
        second_timer_input_pin_prev <= second_timer_input_pin;
        phase_a_prev <= phase_a_input_pin;
    end
end

wire c0_rise = first_timer_input_pin && !first_timer_input_pin_prev;
wire c0_fall = !first_timer_input_pin && first_timer_input_pin_prev;
wire c1_rise = second_timer_input_pin && !second_timer_input_pin_prev;
wire c1_fall = !second_timer_input_pin && second_timer_input_pin_prev;
wire pa_rise = phase_a_input_pin && !phase_a_prev;
wire pa_fall = !phase_a_input_pin && phase_a_prev;

// Polarity 0: count on rising, request and period bound on falling
wire c0_count_edge = tx_pol ? c0_fall : c0_rise;
wire c0_irq_edge = tx_pol ? c0_rise : c0_fall;
wire c1_count_edge = ty_pol ? c1_fall : c1_rise;
wire c1_irq_edge = ty_pol ? c1_rise : c1_fall;
// Pulse width: polarity 0 measures the high level
wire c0_active = first_timer_input_pin ^ tx_pol;

////////////////////////////////////////////////////////////////////////////
// First timer

wire pa_edge = pa_rise || pa_fall;
wire pb_edge = c0_rise || c0_fall;
// Simultaneous edges on both phases carry no direction and are dropped
wire bi_step = (pa_edge ^ pb_edge) && (tx_mode == `DST_TX_BIPHASE);
wire bi_up = pa_edge ? (pa_rise ^ first_timer_input_pin)
                     : (c0_fall ^ phase_a_input_pin);

reg tx_dec;

always @* begin
    case (tx_mode)
        `DST_TX_TIMER: tx_dec = tx_tick;
        `DST_TX_EVENT: tx_dec = c0_count_edge;
        `DST_TX_PWIDTH: tx_dec = tx_tick && c0_active;
        default: tx_dec = 1'b0;
    endcase
end

wire tx_underflow = !tx_stop && tx_dec && (tx_count == 16'h0000);
wire tx_bi_wrap = !tx_stop && bi_step &&
    (bi_up ? (tx_count == 16'hFFFF) : (tx_count == 16'h0000));

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tx_wr_low <= 8'h00;
        tx_latch <= `DST_TIMER_RESET;
        tx_count <= `DST_TIMER_RESET;
    end else begin
        if (wr_tx_low) begin
            tx_wr_low <= bus_wdata;
        end
        if (wr_tx_high) begin
            tx_latch <= {bus_wdata, tx_wr_low};
        end
        if (wr_tx_high && !tx_wrctl) begin
            tx_count <= {bus_wdata, tx_wr_low};
        end else if (tx_stop) begin
            tx_count <= tx_count;
        end else if (bi_step) begin
            if (bi_up) begin
                tx_count <= tx_count + 16'h0001;
            end else begin
                tx_count <= tx_count - 16'h0001;
            end
        end else if (tx_underflow) begin
            tx_count <= tx_latch;
        end else if (tx_dec) begin
            tx_count <= tx_count - 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Second timer

wire ty_cap_mode = (ty_mode == `DST_TY_PERIOD) ||
    (ty_mode == `DST_TY_HLWIDTH);
wire ty_cap_edge = !ty_stop && (
    ((ty_mode == `DST_TY_PERIOD) && c1_irq_edge) ||
    ((ty_mode == `DST_TY_HLWIDTH) && (c1_rise || c1_fall)));
wire ty_dec = (ty_mode == `DST_TY_EVENT) ? c1_count_edge : ty_tick;
wire ty_underflow = !ty_stop && ty_dec && (ty_count == 16'h0000);

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ty_wr_low <= 8'h00;
        ty_latch <= `DST_TIMER_RESET;
        ty_count <= `DST_TIMER_RESET;
        ty_capture <= `DST_TIMER_RESET;
    end else begin
        if (wr_ty_low) begin
            ty_wr_low <= bus_wdata;
        end
        if (wr_ty_high) begin
            ty_latch <= {bus_wdata, ty_wr_low};
        end
        if (ty_cap_edge) begin
            ty_capture <= ty_count;
        end
        if (ty_stop) begin
            ty_count <= ty_count;
        end else if (ty_cap_edge || ty_underflow) begin
            ty_count <= ty_latch;
        end else if (ty_dec) begin
            ty_count <= ty_count - 16'h0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Request flags: a new event wins over a same-cycle clear

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        first_timer_irq <= 1'b0;
        second_timer_irq <= 1'b0;
        first_input_irq <= 1'b0;
        second_input_irq <= 1'b0;
    end else begin
        first_timer_irq <= (tx_underflow || tx_bi_wrap) ||
            (first_timer_irq && !(wr_irq && bus_wdata[`DST_IRQ_TX]));
        second_timer_irq <= ty_underflow ||
            (second_timer_irq && !(wr_irq && bus_wdata[`DST_IRQ_TY]));
        first_input_irq <= c0_irq_edge ||
            (first_input_irq && !(wr_irq && bus_wdata[`DST_IRQ_FIRST_TIMER_INPUT_PIN]));
        second_input_irq <=
            ((ty_mode == `DST_TY_HLWIDTH) ? (c1_rise || c1_fall)
                                          : c1_irq_edge) ||
            (second_input_irq && !(wr_irq && bus_wdata[`DST_IRQ_SECOND_TIMER_INPUT_PIN]));
    end
end

////////////////////////////////////////////////////////////////////////////
// Mode registers and read path

// Capture modes read the edge capture, other modes the live count
wire [15:0] ty_read_src = ty_cap_mode ? ty_capture : ty_count;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        first_timer_mode_reg <= `DST_TXM_RESET;
        second_timer_mode_reg <= `DST_TYM_RESET;
        tx_rd_low <= 8'h00;
        ty_rd_low <= 8'h00;
        bus_rdata <= 8'h00;
    end else begin
        if (wr_txm) begin
            first_timer_mode_reg <= bus_wdata & `DST_TXM_USED;
        end
        if (wr_tym) begin
            second_timer_mode_reg <= bus_wdata;
        end
        if (rd_tx_high) begin
            tx_rd_low <= tx_count[7:0];
        end
        if (rd_ty_high) begin
            ty_rd_low <= ty_read_src[7:0];
        end
        if (bus_rd) begin
            case (bus_addr)
                `DST_ADDR_TX_LOW: bus_rdata <= tx_rd_low;
                `DST_ADDR_TX_HIGH: bus_rdata <= tx_count[15:8];
                `DST_ADDR_TY_LOW: bus_rdata <= ty_rd_low;
                `DST_ADDR_TY_HIGH: bus_rdata <= ty_read_src[15:8];
                `DST_ADDR_TXM: bus_rdata <= first_timer_mode_reg;
                `DST_ADDR_TYM: bus_rdata <= second_timer_mode_reg;
                `DST_ADDR_IRQ: bus_rdata <= {4'h0, second_input_irq,
                    first_input_irq, second_timer_irq, first_timer_irq};
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end
end

endmodule // dst_timers

// [dst_timers_properties.sv]
// Port-level checks for the dual timers
`timescale 1ns/1ns
module dst_timers_properties (
    input wire sys_clk,
    input wire rstn,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata,
    input wire first_timer_input_pin,
    input wire second_timer_input_pin,
    input wire phase_a_input_pin,
    input wire first_timer_irq,
    input wire second_timer_irq,
    input wire first_input_irq,
    input wire second_input_irq
);
////////////////////////////////////////////////////////////////////////
// Cycles since each of the two timer input pins last moved, saturating at 15
reg px;
reg py;
reg [3:0] cx;
reg [3:0] cy;
always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
        px <= 1'b0;
        py <= 1'b0;
        cx <= 4'h0;
        cy <= 4'h0;
    end else begin
        px <= first_timer_input_pin;
        py <= second_timer_input_pin;
        cx <= (first_timer_input_pin != px) ? 4'h0 : cx + {3'h0, cx != 4'hF};
        cy <= (second_timer_input_pin != py) ? 4'h0 : cy + {3'h0, cy != 4'hF};
    end
end
////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rstn);
a_rdata_idle_zero: assert property (
    !$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("Read data outside its cycle");
a_unmapped_read_zero: assert property (
    $past(bus_rd) && ($past(bus_addr) < 8'h18 || $past(bus_addr) == 8'h1E
    || $past(bus_addr) > 8'h1F) |-> bus_rdata == 8'h00)
    else $error("Unmapped read not zero");
a_tym_read_back: assert property (
    bus_wr && bus_addr == 8'h1F ##2 bus_rd && bus_addr == 8'h1F
    |=> bus_rdata == $past(bus_wdata, 3))
    else $error("Second mode register read back wrong");
a_txm_read_back: assert property (
    bus_wr && bus_addr == 8'h1C ##2 bus_rd && bus_addr == 8'h1C
    |=> bus_rdata == ($past(bus_wdata, 3) & 8'h8F))
    else $error("First mode register read back wrong");
a_irq_read_flags: assert property (
    $past(bus_rd && bus_addr == 8'h1D) |-> bus_rdata[3:0] == $past(
    {second_input_irq, first_input_irq, second_timer_irq, first_timer_irq}))
    else $error("Request register read wrong");
a_tx_irq_clear: assert property (
    $fell(first_timer_irq) |-> $past(bus_wr && bus_addr == 8'h1D
    && bus_wdata[0]))
    else $error("Timer request dropped on its own");
a_yin_irq_clear: assert property (
    $fell(second_input_irq) |-> $past(bus_wr && bus_addr == 8'h1D
    && bus_wdata[3]))
    else $error("Input request dropped on its own");
a_xin_edge_cause: assert property (
    $rose(first_input_irq) |-> cx <= 4'h6)
    else $error("Input request without pin edge");
a_yin_edge_cause: assert property (
    $rose(second_input_irq) |-> cy <= 4'h6)
    else $error("Second input request without pin edge");
endmodule // dst_timers_properties

bind dst_timers dst_timers_properties i_props (.sys_clk(sys_clk),
    .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .first_timer_input_pin(first_timer_input_pin),
    .second_timer_input_pin(second_timer_input_pin),
    .phase_a_input_pin(phase_a_input_pin),
    .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq),
    .first_input_irq(first_input_irq), .second_input_irq(second_input_irq));

// [dst_pin_model.sv]
// Pin-side partner: count input, phase pins, measured input
`timescale 1ns/1ns
module dst_pin_model (
    input wire sys_clk,
    output logic pin_x,
    output logic pin_a,
    output logic pin_y
);
initial begin
    pin_x = 1'b0;
    pin_a = 1'b0;
    pin_y = 1'b0;
end
// Levels held several cycles so the sampler never misses one
task tog(input logic y, input int n, input int gap);
    repeat (n) begin
        repeat (gap) @(posedge sys_clk);
        if (y) pin_y <= ~pin_y;
        else pin_x <= ~pin_x;
    end
    repeat (8) @(posedge sys_clk);
endtask
// Gray steps: A and B never move in the same cycle
task quad(input logic up, input int n);
    repeat (n) begin
        repeat (4) @(posedge sys_clk);
        if ((pin_a == pin_x) == up) pin_a <= ~pin_a;
        else pin_x <= ~pin_x;
    end
    repeat (8) @(posedge sys_clk);
endtask
endmodule // dst_pin_model

// [dual_sixteen_bit_timers_bench.sv]
// Self-checking bench for the dual timers
`timescale 1ns/1ns
`include "dst_defs.vh"
module dual_sixteen_bit_timers_bench;
logic sys_clk, rstn, bus_wr, bus_rd, lx, ly;
logic [7:0] bus_addr, bus_wdata, d;
logic [15:0] v0, v1, w0, w1;
logic [31:0] seed;
wire [7:0] bus_rdata;
wire pin_x, pin_y, pin_a, irq_tx, irq_ty, irq_xi, irq_yi;
int n_mismatch, samples_checked, i, p;
int rx [4] = '{4, 8, 16, 128};
int ry [4] = '{8, 16, 32, 4};
dst_timers i_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .first_timer_input_pin(pin_x),
    .second_timer_input_pin(pin_y), .phase_a_input_pin(pin_a),
    .first_timer_irq(irq_tx), .second_timer_irq(irq_ty),
    .first_input_irq(irq_xi), .second_input_irq(irq_yi));
dst_pin_model i_pm (.sys_clk(sys_clk), .pin_x(pin_x), .pin_a(pin_a),
    .pin_y(pin_y));
////////////////////////////////////////////////////////////////////////
function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
endfunction
// Edges counted out of seven toggles from a given start level
function logic [15:0] nedge(input logic lvl, input logic pol);
    nedge = (lvl ^ pol) ? 16'h0003 : 16'h0004;
endfunction
// Within two counts: sync and divider phase blur the edges
function logic near(input logic [15:0] dv, input int e);
    near = (dv + 16'h0002 - e[15:0]) <= 16'h0004;
endfunction
task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    end
endtask
task wr(input logic [7:0] a, input logic [7:0] dd);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= dd;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
endtask
task rd(input logic [7:0] a, output logic [7:0] dd);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 dd = bus_rdata;
endtask
task wr16(input logic y, input logic [15:0] v);
    wr(y ? `DST_ADDR_TY_LOW : `DST_ADDR_TX_LOW, v[7:0]);
    wr(y ? `DST_ADDR_TY_HIGH : `DST_ADDR_TX_HIGH, v[15:8]);
endtask
task rd16(input logic y, output logic [15:0] v);
    rd(y ? `DST_ADDR_TY_HIGH : `DST_ADDR_TX_HIGH, v[15:8]);
    rd(y ? `DST_ADDR_TY_LOW : `DST_ADDR_TX_LOW, v[7:0]);
endtask
task final_report;
    if (n_mismatch == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
end
initial begin
    #1000000;
    n_mismatch++;
    final_report;
end
initial begin
    {rstn, bus_wr, bus_rd, bus_addr, bus_wdata} = 19'h00000;
    seed = 32'h00017C3D;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`DST_ADDR_TYM, d);
    chk(d === `DST_TYM_RESET, "tym reset");
    rd(`DST_ADDR_IRQ, d);
    chk(d === 8'h00, "irq reset");
    rd(8'h1E, d);
    chk(d === 8'h00, "unmapped");
    for (i = 0; i < 8; i++) begin
        seed = xs(seed);
        wr(`DST_ADDR_TYM, seed[7:0]);
        rd(`DST_ADDR_TYM, d);
        chk(d === seed[7:0], "tym rw");
        wr(`DST_ADDR_TXM, seed[15:8]);
        rd(`DST_ADDR_TXM, d);
        chk(d === (seed[15:8] & `DST_TXM_USED), "txm rw");
    end
    wr(`DST_ADDR_TYM, 8'h80);
    rd16(1'b1, w0);
    wr16(1'b1, seed[31:16]);
    repeat (100) @(posedge sys_clk);
    rd16(1'b1, w1);
    chk(w1 === w0, "ty stop latch");
    wr(`DST_ADDR_TXM, 8'h80);
    wr16(1'b0, seed[15:0]);
    repeat (100) @(posedge sys_clk);
    rd16(1'b0, v0);
    chk(v0 === seed[15:0], "tx load");
    wr16(1'b0, 16'h8000);
    wr(`DST_ADDR_TXM, 8'h00);
    for (i = 0; i < 4; i++) begin
        wr(`DST_ADDR_TYM, {4'h0, i[1:0], i[1:0]});
        rd16(1'b0, v0);
        rd16(1'b1, w0);
        repeat (640) @(posedge sys_clk);
        rd16(1'b0, v1);
        rd16(1'b1, w1);
        chk(near(v0 - v1, 640 / rx[i]), "x rate");
        chk(near(w0 - w1, 640 / ry[i]), "y rate");
    end
    // Write control 1: counter keeps 3, latch holds 0x10
    wr(`DST_ADDR_TXM, 8'h80);
    wr16(1'b0, 16'h0003);
    wr(`DST_ADDR_TXM, 8'h81);
    wr16(1'b0, 16'h0010);
    rd16(1'b0, v0);
    chk(v0 === 16'h0003, "wrctl");
    wr(`DST_ADDR_TYM, 8'h00);
    wr(`DST_ADDR_IRQ, 8'h0F);
    wr(`DST_ADDR_TXM, 8'h01);
    for (i = 0; i < 100 && irq_tx !== 1'b1; i++) @(posedge sys_clk);
    wr(`DST_ADDR_TXM, 8'h81);
    rd16(1'b0, v1);
    chk(irq_tx === 1'b1 && near(v1, 14), "reload");
    wr(`DST_ADDR_IRQ, 8'h01);
    rd(`DST_ADDR_IRQ, d);
    chk(d[0] === 1'b0, "irq clear");
    wr(`DST_ADDR_TXM, 8'h80);
    wr16(1'b0, 16'h0001);
    wr(`DST_ADDR_TXM, 8'h02);
    i_pm.quad(1'b0, 3);
    chk(irq_tx === 1'b1, "quad under");
    wr(`DST_ADDR_IRQ, 8'h01);
    i_pm.quad(1'b1, 8);
    rd16(1'b0, v0);
    chk(irq_tx === 1'b1 && v0 === 16'h0006, "quad");
    // Headroom so event and width counts never reach underflow
    wr16(1'b0, 16'h1000);
    for (p = 0; p < 2; p++) begin
        wr(`DST_ADDR_TXM, p ? 8'h0C : 8'h04);
        wr(`DST_ADDR_TYM, p ? 8'h60 : 8'h20);
        rd16(1'b0, v0);
        rd16(1'b1, w0);
        lx = pin_x;
        ly = pin_y;
        i_pm.tog(1'b0, 7, 4);
        i_pm.tog(1'b1, 7, 4);
        rd16(1'b0, v1);
        rd16(1'b1, w1);
        chk(v0 - v1 === nedge(lx, p[0]), "x event");
        chk(w0 - w1 === nedge(ly, p[0]), "y event");
    end
    wr(`DST_ADDR_TYM, 8'h00);
    wr(`DST_ADDR_TXM, 8'h06);
    if (pin_x === 1'b1) i_pm.tog(1'b0, 1, 4);
    wr(`DST_ADDR_IRQ, 8'h0F);
    rd16(1'b0, v0);
    i_pm.tog(1'b0, 2, 80);
    rd16(1'b0, v1);
    chk(near(v0 - v1, 20) && irq_xi === 1'b1, "width");
    wr16(1'b1, 16'h0100);
    for (p = 0; p < 3; p++) begin
        wr(`DST_ADDR_TYM, p == 0 ? 8'h10 : (p == 1 ? 8'h50 : 8'h30));
        wr(`DST_ADDR_IRQ, 8'h0F);
        i_pm.tog(1'b1, 4, p == 2 ? 80 : 40);
        rd16(1'b1, w0);
        chk(near(w0, 246) && irq_yi === 1'b1, "capture");
    end
    // Y latch write lands in the counter only at underflow or a capture edge
    wr16(1'b1, 16'h0003);
    wr(`DST_ADDR_TYM, 8'h0C);
    wr(`DST_ADDR_IRQ, 8'h0F);
    for (i = 0; i < 1500 && irq_ty !== 1'b1; i++) @(posedge sys_clk);
    rd16(1'b1, w0);
    chk(irq_ty === 1'b1 && w0 <= 16'h0003, "y under");
    final_report;
end
endmodule // dual_sixteen_bit_timers_bench
